// ===== rtl/ioc_pkg.sv
package ioc_pkg;

  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned N_ELEM = 3;

  // register byte addresses
  localparam logic [APB_AW-1:0] ADDR_CFG  = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STAT = 8'h04;

  // storage element indices
  localparam int unsigned EL_IN  = 0;
  localparam int unsigned EL_OUT = 1;
  localparam int unsigned EL_OE  = 2;

  // boundary-scan chain cell indices
  localparam int unsigned BS_OUT = 0;
  localparam int unsigned BS_OE  = 1;
  localparam int unsigned BS_IN  = 2;

  typedef enum logic [1:0] {
    SR_SYNC_SET  = 2'b00,
    SR_SYNC_RST  = 2'b01,
    SR_ASYNC_PRE = 2'b10,
    SR_ASYNC_CLR = 2'b11
  } ioc_sr_e;

  typedef struct packed {
    logic    latch;
    ioc_sr_e srmode;
  } ioc_elem_cfg_s;

  typedef struct packed {
    logic                           cfg_done;
    logic                           keeper_en;
    logic                           pullup_post;
    logic                           pulldown_post;
    logic                           inv_sr;
    logic          [N_ELEM-1:0]     inv_ce;
    logic                           inv_clk;
    logic                           inv_oe;
    logic                           inv_out;
    logic                           oe_sel_reg;
    logic                           out_sel_reg;
    ioc_elem_cfg_s [N_ELEM-1:0]     elem;
  } ioc_cfg_s;

  localparam int unsigned CFG_W = $bits(ioc_cfg_s);
  localparam logic [CFG_W-1:0] CFG_RST = 21'h000000;

  typedef struct packed {
    logic              strap_pullup;
    logic              cfg_done;
    logic [N_ELEM-1:0] q;
    logic              pad_in;
  } ioc_stat_s;

  localparam int unsigned STAT_W = $bits(ioc_stat_s);

endpackage

// ===== rtl/ioc_store_elem.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_store_elem
  import ioc_pkg::*;
(
  input  wire logic          i_clk,      // system clock
  input  wire logic          i_rst_b,    // async reset, active low
  input  wire logic          i_ce,       // global freeze when low
  input  wire ioc_elem_cfg_s i_cfg,      // mode and set/reset style
  input  wire logic          i_clk_rise, // cell clock rising edge
  input  wire logic          i_clk_hi,   // cell clock level
  input  wire logic          i_elem_ce,  // element clock enable
  input  wire logic          i_sr,       // shared set/reset
  input  wire logic          i_d,        // data in
  output logic               o_q         // stored value
);

  typedef struct packed {
    logic q;
  } ioc_el_st_s;

  ioc_el_st_s st_r;
  ioc_el_st_s st_nxt;
  logic       load;

  always_comb
  begin
    st_nxt = st_r;
    load   = i_elem_ce && (i_cfg.latch ? i_clk_hi : i_clk_rise); // R1 R2 R12
    if (i_ce)
    begin
      if (i_sr && i_cfg.srmode == SR_ASYNC_PRE)
        st_nxt.q = 1'b1; // R3
      else if (i_sr && i_cfg.srmode == SR_ASYNC_CLR)
        st_nxt.q = 1'b0; // R3
      else if (load)
      begin
        if (i_sr && i_cfg.srmode == SR_SYNC_SET)
          st_nxt.q = 1'b1; // R3
        else if (i_sr && i_cfg.srmode == SR_SYNC_RST)
          st_nxt.q = 1'b0; // R3
        else
          st_nxt.q = i_d;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_q = st_r.q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic async_act;
  assign async_act = i_sr && i_cfg.srmode[1];

  property p_hold_no_ce;
    (i_ce && !i_elem_ce && !async_act) |=> $stable(o_q);
  endproperty
  a_hold_no_ce: assert property (p_hold_no_ce) else $error("element changed with enable low"); // R12

  property p_async_clr;
    (i_ce && i_sr && i_cfg.srmode == SR_ASYNC_CLR) |=> !o_q;
  endproperty
  a_async_clr: assert property (p_async_clr) else $error("async clear not applied"); // R3

  property p_sync_set;
    (i_ce && i_sr && i_elem_ce && i_clk_rise && !i_cfg.latch
      && i_cfg.srmode == SR_SYNC_SET) |=> o_q;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync set not applied"); // R3

  property p_ff_edge_only;
    (i_ce && !i_cfg.latch && !i_clk_rise && !async_act) |=> $stable(o_q);
  endproperty
  a_ff_edge_only: assert property (p_ff_edge_only) else $error("flip-flop moved off edge"); // R1

endmodule
`default_nettype wire

// ===== rtl/ioc_cell.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - each of the three storage elements works as an edge flip-flop or a level latch.
// R2 - the three elements share one cell clock but each has its own clock enable.
// R3 - one shared set/reset acts per element as sync set, sync reset, async preset or clear.
// R4 - output data and every control signal have their own polarity inversion.
// R5 - before configuration is done outputs float, pull-downs and keeper stay off.
// R6 - pre-configuration pull-ups follow one global strap; otherwise pins float.
// R7 - the pad input reaches logic directly and through the input element at once.
// R8 - pad data comes from logic directly or from the output element by configuration.
// R9 - driver enable comes from logic directly or from the enable element.
// R10 - with the keeper on and drivers off, the pad is held at its last sensed level.
// R11 - the cell takes part in boundary scan with capture, shift, update and extest.
// R12 - an element with its enable low keeps its value apart from async preset or clear.
module ioc_cell
  import ioc_pkg::*;
(
  input  wire logic              i_clk,          // system clock, 20 MHz
  input  wire logic              i_rst_b,        // async reset, active low
  input  wire logic              i_ce,           // global clock enable
  input  wire logic              i_psel,         // apb select
  input  wire logic              i_penable,      // apb enable
  input  wire logic              i_pwrite,       // apb direction
  input  wire logic [APB_AW-1:0] i_paddr,        // apb address
  input  wire logic [APB_DW-1:0] i_pwdata,       // apb write data
  output logic      [APB_DW-1:0] o_prdata,       // apb read data
  output logic                   o_pready,       // apb ready
  output logic                   o_pslverr,      // apb error
  input  wire logic              i_mode_pullup,  // global pull-up strap
  input  wire logic              i_cell_clk,     // shared cell clock
  input  wire logic [N_ELEM-1:0] i_elem_ce,      // per element enables
  input  wire logic              i_sr,           // shared set/reset
  input  wire logic              i_out_data,     // data to pad
  input  wire logic              i_oe_data,      // driver enable, high drives
  output logic                   o_in_direct,    // pad value, direct path
  output logic                   o_in_reg,       // pad value, stored path
  input  wire logic              i_pad_in,       // sensed pad level
  output logic                   o_pad_out,      // pad driver data
  output logic                   o_pad_oe,       // pad driver enable
  output logic                   o_pullup_en,    // pull-up on
  output logic                   o_pulldown_en,  // pull-down on
  output logic                   o_keep_oe,      // keeper weak drive on
  output logic                   o_keep_val,     // keeper weak level
  input  wire logic              i_bs_capture,   // scan capture
  input  wire logic              i_bs_shift,     // scan shift
  input  wire logic              i_bs_update,    // scan update
  input  wire logic              i_bs_extest,    // scan owns the pad
  input  wire logic              i_bs_tdi,       // scan data in
  output logic                   o_bs_tdo        // scan data out
);

  typedef struct packed {
    ioc_cfg_s          cfg;
    logic              strap_done;
    logic              strap;
    logic              clk_prev;
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
    logic              pad_out;
    logic              pad_oe;
    logic              pu;
    logic              pd;
    logic              keep_oe;
    logic              keep_val;
    logic              in_direct;
    logic [N_ELEM-1:0] bs_chain;
    logic [N_ELEM-1:0] bs_upd;
    logic              bs_tdo;
  } ioc_st_s;

  ioc_st_s           st_r;
  ioc_st_s           st_nxt;
  logic [N_ELEM-1:0] q;
  logic [N_ELEM-1:0] d;
  logic [N_ELEM-1:0] ce_eff;
  logic              clk_eff;
  logic              clk_rise;
  logic              sr_eff;
  logic              out_fn;
  logic              oe_fn;
  logic              apb_done;
  logic              addr_ok;
  ioc_stat_s         stat;

  assign clk_eff  = i_cell_clk ^ st_r.cfg.inv_clk; // R4
  assign clk_rise = clk_eff && !st_r.clk_prev;     // R2
  assign sr_eff   = i_sr ^ st_r.cfg.inv_sr;        // R4
  assign d[EL_IN]  = i_pad_in;                     // R7
  assign d[EL_OUT] = i_out_data;
  assign d[EL_OE]  = i_oe_data;

  genvar g;
  generate
    for (g = 0; g < N_ELEM; g++)
    begin : g_elem
      assign ce_eff[g] = i_elem_ce[g] ^ st_r.cfg.inv_ce[g]; // R4
      ioc_store_elem u_elem (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_ce       (i_ce),
        .i_cfg      (st_r.cfg.elem[g]),
        .i_clk_rise (clk_rise),
        .i_clk_hi   (clk_eff),
        .i_elem_ce  (ce_eff[g]),
        .i_sr       (sr_eff),
        .i_d        (d[g]),
        .o_q        (q[g])
      );
    end
  endgenerate

  // output data and enable select, then polarity
  assign out_fn = (st_r.cfg.out_sel_reg ? q[EL_OUT] : i_out_data) ^ st_r.cfg.inv_out; // R8 R4
  assign oe_fn  = (st_r.cfg.oe_sel_reg ? q[EL_OE] : i_oe_data) ^ st_r.cfg.inv_oe;    // R9 R4

  assign apb_done = i_psel && i_penable && st_r.pready;
  assign addr_ok  = (i_paddr == ADDR_CFG) || (i_paddr == ADDR_STAT);

  always_comb
  begin
    st_nxt = st_r;
    stat.strap_pullup = st_r.strap;
    stat.cfg_done     = st_r.cfg.cfg_done;
    stat.q            = q;
    stat.pad_in       = i_pad_in;
    if (i_ce)
    begin
      // strap caught once, first enabled cycle after reset release
      if (!st_r.strap_done)
      begin
        st_nxt.strap_done = 1'b1;
        st_nxt.strap      = i_mode_pullup; // R6
      end
      st_nxt.clk_prev = clk_eff;

      // apb slave: one wait state, then ready
      st_nxt.pready  = i_psel && i_penable && !st_r.pready;
      st_nxt.pslverr = i_psel && i_penable && !st_r.pready && !addr_ok;
      if (i_psel && i_penable && !st_r.pready)
      begin
        if (i_pwrite || !addr_ok)
          st_nxt.prdata = '0;
        else if (i_paddr == ADDR_CFG)
          st_nxt.prdata = APB_DW'(st_r.cfg);
        else
          st_nxt.prdata = APB_DW'(stat);
      end
      if (apb_done && i_pwrite && i_paddr == ADDR_CFG)
        st_nxt.cfg = ioc_cfg_s'(i_pwdata[CFG_W-1:0]);

      st_nxt.in_direct = i_pad_in; // R7

      // boundary-scan cells
      st_nxt.bs_tdo = st_r.bs_chain[0];
      if (i_bs_capture)
        st_nxt.bs_chain = {i_pad_in, oe_fn, out_fn}; // R11
      else if (i_bs_shift)
        st_nxt.bs_chain = {i_bs_tdi, st_r.bs_chain[N_ELEM-1:1]}; // R11
      if (i_bs_update)
        st_nxt.bs_upd = st_r.bs_chain; // R11

      // pad drive
      if (!st_r.cfg.cfg_done)
      begin
        st_nxt.pad_out = 1'b0;
        st_nxt.pad_oe  = 1'b0;           // R5
        st_nxt.pd      = 1'b0;           // R5
        st_nxt.keep_oe = 1'b0;           // R5
        st_nxt.pu      = st_nxt.strap;   // R6
      end
      else
      begin
        st_nxt.pad_out = i_bs_extest ? st_r.bs_upd[BS_OUT] : out_fn; // R8 R11
        st_nxt.pad_oe  = i_bs_extest ? st_r.bs_upd[BS_OE] : oe_fn;   // R9 R11
        st_nxt.pu      = st_r.cfg.pullup_post;
        st_nxt.pd      = st_r.cfg.pulldown_post;
        st_nxt.keep_oe = st_r.cfg.keeper_en && !st_nxt.pad_oe;       // R10
      end
      st_nxt.keep_val = i_pad_in; // R10
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_r     <= '0;
      st_r.cfg <= CFG_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign o_prdata      = st_r.prdata;
  assign o_pready      = st_r.pready;
  assign o_pslverr     = st_r.pslverr;
  assign o_in_direct   = st_r.in_direct;
  assign o_in_reg      = q[EL_IN];
  assign o_pad_out     = st_r.pad_out;
  assign o_pad_oe      = st_r.pad_oe;
  assign o_pullup_en   = st_r.pu;
  assign o_pulldown_en = st_r.pd;
  assign o_keep_oe     = st_r.keep_oe;
  assign o_keep_val    = st_r.keep_val;
  assign o_bs_tdo      = st_r.bs_tdo;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_preconfig_float;
    (i_ce && !st_r.cfg.cfg_done) |=> (!o_pad_oe && !o_pulldown_en && !o_keep_oe);
  endproperty
  a_preconfig_float: assert property (p_preconfig_float) else $error("pad driven before config"); // R5

  property p_preconfig_pullup;
    (i_ce && !st_r.cfg.cfg_done && st_r.strap_done) |=> (o_pullup_en == $past(st_r.strap));
  endproperty
  a_preconfig_pullup: assert property (p_preconfig_pullup) else $error("pull-up not strap"); // R6

  property p_direct_in;
    (i_rst_b && i_ce) |=> (o_in_direct == $past(i_pad_in));
  endproperty
  a_direct_in: assert property (p_direct_in) else $error("direct input path wrong"); // R7

  property p_out_direct;
    (i_ce && st_r.cfg.cfg_done && !st_r.cfg.out_sel_reg && !i_bs_extest)
      |=> (o_pad_out == ($past(i_out_data) ^ $past(st_r.cfg.inv_out)));
  endproperty
  a_out_direct: assert property (p_out_direct) else $error("direct output path wrong"); // R8

  property p_oe_reg;
    (i_ce && st_r.cfg.cfg_done && st_r.cfg.oe_sel_reg && !i_bs_extest)
      |=> (o_pad_oe == ($past(q[EL_OE]) ^ $past(st_r.cfg.inv_oe)));
  endproperty
  a_oe_reg: assert property (p_oe_reg) else $error("stored enable path wrong"); // R9

  property p_keeper;
    (i_ce && st_r.cfg.cfg_done && st_r.cfg.keeper_en) |=> (o_keep_oe == !o_pad_oe);
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper not active when undriven"); // R10

  sequence s_bs_load;
    i_ce && i_bs_capture && !i_bs_update && !i_bs_shift;
  endsequence
  sequence s_bs_shift_out;
    i_ce && i_bs_shift && !i_bs_capture;
  endsequence
  property p_bs_capture_shift;
    bit cap;
    (s_bs_load, cap = out_fn) ##1 s_bs_shift_out |=> (o_bs_tdo == cap);
  endproperty
  a_bs_capture_shift: assert property (p_bs_capture_shift) else $error("scan capture lost"); // R11

  property p_preconfig_low;
    (i_ce && !st_r.cfg.cfg_done) |=> !o_pad_out;
  endproperty
  a_preconfig_low: assert property (p_preconfig_low) else $error("pad data early"); // R5

  property p_strap_once;
    (i_ce && st_r.strap_done) |=> $stable(st_r.strap);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("pull-up strap caught twice"); // R6

  property p_keep_val;
    (i_rst_b && i_ce) |=> (o_keep_val == $past(i_pad_in));
  endproperty
  a_keep_val: assert property (p_keep_val) else $error("keeper level stale"); // R10

  property p_oe_direct;
    (i_ce && st_r.cfg.cfg_done && !st_r.cfg.oe_sel_reg && !i_bs_extest)
      |=> (o_pad_oe == ($past(i_oe_data) ^ $past(st_r.cfg.inv_oe)));
  endproperty
  a_oe_direct: assert property (p_oe_direct) else $error("direct enable path wrong"); // R9

  property p_out_reg;
    (i_ce && st_r.cfg.cfg_done && st_r.cfg.out_sel_reg && !i_bs_extest)
      |=> (o_pad_out == ($past(q[EL_OUT]) ^ $past(st_r.cfg.inv_out)));
  endproperty
  a_out_reg: assert property (p_out_reg) else $error("stored output path wrong"); // R8

  property p_bs_shift;
    (i_ce && i_bs_shift && !i_bs_capture)
      |=> (st_r.bs_chain == {$past(i_bs_tdi), $past(st_r.bs_chain[N_ELEM-1:1])});
  endproperty
  a_bs_shift: assert property (p_bs_shift) else $error("scan shift wrong"); // R11

  property p_bs_update;
    (i_ce && i_bs_update) |=> (st_r.bs_upd == $past(st_r.bs_chain));
  endproperty
  a_bs_update: assert property (p_bs_update) else $error("scan update lost"); // R11

  property p_bs_extest;
    (i_ce && st_r.cfg.cfg_done && i_bs_extest)
      |=> (o_pad_out == $past(st_r.bs_upd[BS_OUT]) && o_pad_oe == $past(st_r.bs_upd[BS_OE]));
  endproperty
  a_bs_extest: assert property (p_bs_extest) else $error("scan not on pad"); // R11

  property p_ce_freeze;
    (i_rst_b && !i_ce) |=> $stable(st_r);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen"); // R12

endmodule
`default_nettype wire

// ===== dv/ioc_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_pad_model
(
  input  wire logic i_clk,      // system clock
  input  wire logic i_pad_oe,   // cell driver on
  input  wire logic i_pad_out,  // cell driver level
  input  wire logic i_pull_up,  // pull-up on
  input  wire logic i_pull_dn,  // pull-down on
  input  wire logic i_keep_oe,  // keeper weak drive on
  input  wire logic i_keep_val, // keeper level
  input  wire logic i_ext_oe,   // far-side driver on
  input  wire logic i_ext_val,  // far-side level
  output logic      o_pad       // resolved pad level
);
  logic float_r = 1'b0;

  // undriven pad wanders every cycle
  always_ff @(posedge i_clk)
    float_r <= ~float_r;

  always_comb
  begin
    if (i_pad_oe)
      o_pad = i_pad_out;
    else if (i_ext_oe)
      o_pad = i_ext_val;
    else if (i_keep_oe)
      o_pad = i_keep_val;
    else if (i_pull_up)
      o_pad = 1'b1;
    else if (i_pull_dn)
      o_pad = 1'b0;
    else
      o_pad = float_r;
  end
endmodule
`default_nettype wire

// ===== dv/io_cell_registers_tb.sv
`timescale 1ns/1ns
`default_nettype none
module io_cell_registers_tb;
  import ioc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, cclk = 1'b0, sr = 1'b0, out_d = 1'b0, oe_d = 1'b0;
  logic [2:0] ece = 3'h7;
  logic in_dir, in_reg, pad_in, pad_out, pad_oe, pu, pd, koe, kval, tdo;
  logic cap = 1'b0, sh = 1'b0, ext_oe = 1'b0, ext_val = 1'b0;
  logic ce = 1'b1, upd = 1'b0, ext = 1'b0, tdi = 1'b0;
  int n_errors = 0, n_compared = 0, cycles = 0;
  ioc_cfg_s c;

  always #25 clk = ~clk;

  ioc_cell i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mode_pullup(1'b1),
    .i_cell_clk(cclk), .i_elem_ce(ece), .i_sr(sr), .i_out_data(out_d), .i_oe_data(oe_d),
    .o_in_direct(in_dir), .o_in_reg(in_reg), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_pullup_en(pu), .o_pulldown_en(pd), .o_keep_oe(koe),
    .o_keep_val(kval), .i_bs_capture(cap), .i_bs_shift(sh), .i_bs_update(upd),
    .i_bs_extest(ext), .i_bs_tdi(tdi), .o_bs_tdo(tdo));

  ioc_pad_model i_pad (.i_clk(clk), .i_pad_oe(pad_oe), .i_pad_out(pad_out),
    .i_pull_up(pu), .i_pull_dn(pd), .i_keep_oe(koe), .i_keep_val(kval),
    .i_ext_oe(ext_oe), .i_ext_val(ext_val), .o_pad(pad_in));

  task automatic summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wcfg;
    logic [31:0] rd;
    logic e;
    apb(1'b1, ADDR_CFG, 32'(c), rd, e);
    cyc(3);
  endtask

  task automatic pulse;
    cclk <= 1'b1;
    cyc(3);
    cclk <= 1'b0;
    cyc(3);
  endtask

  task automatic t_pre;
    logic [31:0] rd;
    logic e;
    ioc_stat_s st;
    chk("pad_oe", 0, pad_oe);
    chk("pulldown", 0, pd);
    chk("keep_oe", 0, koe);
    chk("pullup", 1, pu);
    apb(1'b0, ADDR_STAT, '0, rd, e);
    st = ioc_stat_s'(rd[STAT_W-1:0]);
    chk("strap", 1, st.strap_pullup);
    chk("cfg_done", 0, st.cfg_done);
    apb(1'b0, ADDR_CFG, '0, rd, e);
    chk("cfg_rst", 0, rd);
    apb(1'b0, 8'h08, '0, rd, e);
    chk("slverr", 1, e);
    apb(1'b1, ADDR_STAT, 32'hffffffff, rd, e);
    chk("stat_wr_err", 0, e);
  endtask

  task automatic t_out;
    c = '0;
    c.cfg_done = 1'b1;
    out_d <= 1'b1;
    oe_d <= 1'b1;
    wcfg();
    chk("pad_out", 1, pad_out);
    chk("pad_oe", 1, pad_oe);
    c.inv_out = 1'b1;
    c.inv_oe = 1'b1;
    wcfg();
    chk("pad_out_inv", 0, pad_out);
    chk("pad_oe_inv", 0, pad_oe);
    c = '0;
    c.cfg_done = 1'b1;
    c.out_sel_reg = 1'b1;
    c.oe_sel_reg = 1'b1;
    out_d <= 1'b0;
    oe_d <= 1'b0;
    wcfg();
    pulse();
    out_d <= 1'b1;
    oe_d <= 1'b1;
    cyc(3);
    chk("pad_out_held", 0, pad_out);
    chk("pad_oe_held", 0, pad_oe);
    pulse();
    chk("pad_out_reg", 1, pad_out);
    chk("pad_oe_reg", 1, pad_oe);
    oe_d <= 1'b0;
  endtask

  task automatic t_in;
    c = '0;
    c.cfg_done = 1'b1;
    wcfg();
    ext_oe <= 1'b1;
    ext_val <= 1'b1;
    pulse();
    chk("in_direct", 1, in_dir);
    chk("in_reg", 1, in_reg);
    ext_val <= 1'b0;
    cyc(3);
    chk("in_direct", 0, in_dir);
    chk("in_reg_ff", 1, in_reg);
    ece <= 3'h6;
    pulse();
    chk("in_reg_ce", 1, in_reg);
    ece <= 3'h7;
    pulse();
    chk("in_reg_load", 0, in_reg);
    c.elem[EL_IN].latch = 1'b1;
    wcfg();
    cclk <= 1'b1;
    ext_val <= 1'b1;
    cyc(3);
    chk("latch_open", 1, in_reg);
    cclk <= 1'b0;
    cyc(2);
    ext_val <= 1'b0;
    cyc(3);
    chk("latch_shut", 1, in_reg);
  endtask

  task automatic t_sr;
    for (int m = 0; m < 4; m++)
    begin
      c = '0;
      c.cfg_done = 1'b1;
      c.elem[EL_IN].srmode = ioc_sr_e'(m);
      wcfg();
      ext_val <= m[0];
      pulse();
      chk("sr_pre", m[0], in_reg);
      sr <= 1'b1;
      if (m[1])
      begin
        ece <= 3'h6;
        cyc(3);
      end
      else
        pulse();
      chk("sr_mode", !m[0], in_reg);
      sr <= 1'b0;
      ece <= 3'h7;
      cyc(1);
    end
  endtask

  task automatic t_keep;
    c = '0;
    c.cfg_done = 1'b1;
    c.keeper_en = 1'b1;
    wcfg();
    ext_val <= 1'b1;
    cyc(3);
    chk("keep_oe", 1, koe);
    ext_oe <= 1'b0;
    cyc(4);
    chk("keep_hold1", 1, pad_in);
    chk("keep_val1", 1, kval);
    ext_oe <= 1'b1;
    ext_val <= 1'b0;
    cyc(3);
    ext_oe <= 1'b0;
    cyc(4);
    chk("keep_hold0", 0, pad_in);
    oe_d <= 1'b1;
    cyc(3);
    chk("keep_off", 0, koe);
    oe_d <= 1'b0;
  endtask

  task automatic t_scan;
    logic [2:0] exp;
    c = '0;
    c.cfg_done = 1'b1;
    out_d <= 1'b1;
    ext_oe <= 1'b1;
    ext_val <= 1'b1;
    wcfg();
    exp = 3'h5;
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    sh <= 1'b1;
    tdi <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      @(negedge clk);
      chk("scan_tdo", exp[k], tdo);
    end
    @(posedge clk);
    sh <= 1'b0;
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    ext <= 1'b1;
    out_d <= 1'b0;
    cyc(3);
    chk("extest_out", 1, pad_out);
    chk("extest_oe", 1, pad_oe);
    ext <= 1'b0;
    tdi <= 1'b0;
    cyc(3);
    chk("extest_off", 0, pad_oe);
  endtask

  task automatic t_ce;
    c = '0;
    c.cfg_done = 1'b1;
    wcfg();
    ext_oe <= 1'b1;
    ext_val <= 1'b1;
    pulse();
    ce <= 1'b0;
    ext_val <= 1'b0;
    pulse();
    chk("ce_hold_reg", 1, in_reg);
    chk("ce_hold_dir", 1, in_dir);
    ce <= 1'b1;
    pulse();
    chk("ce_run_reg", 0, in_reg);
  endtask

  task automatic t_inv;
    c = '0;
    c.cfg_done = 1'b1;
    c.inv_ce[EL_IN] = 1'b1;
    wcfg();
    ext_val <= 1'b1;
    pulse();
    chk("inv_ce", 0, in_reg);
    c.inv_ce = '0;
    c.inv_sr = 1'b1;
    c.elem[EL_IN].srmode = SR_SYNC_RST;
    wcfg();
    pulse();
    chk("inv_sr", 0, in_reg);
    c.inv_sr = 1'b0;
    wcfg();
    pulse();
    chk("inv_none", 1, in_reg);
  endtask

  initial
  begin
    cyc(20);
    rst_b <= 1'b1;
    cyc(3);
    t_pre();
    t_out();
    t_in();
    t_sr();
    t_keep();
    t_ce();
    t_inv();
    t_scan();
    summarize();
  end
endmodule
`default_nettype wire
